// ### design/serial_port_pkg.sv
// constants, register map and state codes of the serial port transmit clocking
package serial_port_pkg;
  // =========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4; // pclk period
  localparam int unsigned H_PER_CYCLE = 2; // H is half a pclk cycle
  localparam int unsigned EXTRA_HOLD_H = 4; // extra first-bit delay, in H
  localparam int unsigned EXTRA_HOLD_CYCLES = EXTRA_HOLD_H / H_PER_CYCLE;
  localparam int unsigned MIN_PERIOD_H = 4; // fastest internal shift clock
  localparam int unsigned MIN_DIVIDE = MIN_PERIOD_H / H_PER_CYCLE - 1;
  // =========================================================
  // widths
  localparam int unsigned DIV_W = 8;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned BIT_W = 4;
  localparam int unsigned ADDR_W = 12;
  // =========================================================
  // register offsets
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] TXDATA_ADDR = 12'h004;
  localparam logic [11:0] STATUS_ADDR = 12'h008;
  // =========================================================
  // control field positions
  localparam int unsigned DIV_LSB = 0;
  localparam int unsigned TX_CLK_POL_BIT = 8;
  localparam int unsigned RX_CLK_POL_BIT = 9;
  localparam int unsigned TX_SYNC_POL_BIT = 10;
  localparam int unsigned RX_SYNC_POL_BIT = 11;
  localparam int unsigned DELAY_LSB = 12;
  localparam int unsigned EXTRA_EN_BIT = 14;
  localparam int unsigned PORT_EN_BIT = 15;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] TXDATA_RESET = 16'h0000;
  // =========================================================
  // data delay codes
  localparam logic [1:0] DELAY_NONE = 2'h0;
  localparam logic [1:0] DELAY_ONE = 2'h1;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DELAY = 3'b010,
    ST_SHIFT = 3'b100
  } tx_state_e;
endpackage

// ### design/serial_port_tx.sv
// serial port shift clock generator, frame syncs and transmit launch
//
// What this block does
// R1: each polarity bit inverts the edge sense of its own clock or sync pin.
// R2: internal shift clock period is (1 + divide) cycles of 2H.
// R3: low phase is half period for zero/odd divide, divide/2 x 2H if even.
// R4: high phase is half period for zero/odd, (divide/2 + 1) x 2H if even.
// R5: internal shift clock never runs faster than a 4H period.
// R6: internal receive frame sync changes after a receive clock rising edge.
// R7: internal transmit frame sync changes after a transmit clock rising edge.
// R8: bits after the first are driven out after a transmit clock rise.
// R9: with one or two bit delay the first bit launches from a clock rise.
// R10: with no delay the first bit launches with the frame sync rise.
// R11: extra-enable option holds first bit output enable back by 4H; data is set at launch.
// R12: after the last bit the output releases to high impedance on a rise.
// R13: data output is driven only while frame bits shift, else released.
`timescale 1ns/1ps
module serial_port_tx (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_shift_clock,
  output logic rx_shift_clock,
  output logic tx_frame_sync,
  output logic rx_frame_sync,
  output logic tx_serial_out,
  output logic tx_serial_oe_n
);
  localparam logic [7:0] MIN_DIV = 8'(serial_port_pkg::MIN_DIVIDE);
  localparam logic [3:0] LAST_BIT = 4'(serial_port_pkg::WORD_BITS - 1);
  localparam logic [1:0] HOLD_INIT =
    2'(serial_port_pkg::EXTRA_HOLD_CYCLES);
  // parked count is at or above any divide, so enabling always starts on a rise
  localparam logic [7:0] CNT_PARK = 8'hFF;

  logic [15:0] ctrl, next_ctrl;
  logic [15:0] tx_hold, next_tx_hold;
  logic pending, next_pending;
  logic [31:0] next_prdata;
  logic [7:0] cnt, next_cnt;
  logic sclk, next_sclk;
  logic [15:0] shreg, next_shreg;
  logic [3:0] bitcnt, next_bitcnt;
  logic dly_left, next_dly_left;
  logic [1:0] hold, next_hold;
  logic tx_out, next_tx_out;
  logic oe_n, next_oe_n;
  logic fs, next_fs;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic rx_fs, next_rx_fs;
  serial_port_pkg::tx_state_e state, next_state;

  logic [7:0] divide, div_eff, high_len;
  logic [1:0] delay;
  logic en, extra, rise, launch, acc, wr, mapped;

  // =========================================================
  // control fields
  assign divide = ctrl[serial_port_pkg::DIV_LSB +: 8];
  assign delay = ctrl[serial_port_pkg::DELAY_LSB +: 2];
  assign en = ctrl[serial_port_pkg::PORT_EN_BIT];
  assign extra = ctrl[serial_port_pkg::EXTRA_EN_BIT];
  // clamp keeps the clock at or below the fastest legal rate
  assign div_eff = (divide < MIN_DIV) ? MIN_DIV : divide; // R5
  // (d>>1)+1 gives half of an even period and d/2+1 for even d
  assign high_len = (div_eff >> 1) + 8'h01; // R3 R4
  assign rise = en && (cnt >= div_eff); // R2

  // =========================================================
  // apb slave: zero wait states, read data latched in setup
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign mapped = (paddr == serial_port_pkg::CTRL_ADDR) ||
                  (paddr == serial_port_pkg::TXDATA_ADDR) ||
                  (paddr == serial_port_pkg::STATUS_ADDR && !pwrite);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // register file next values
  always_comb begin
    next_ctrl = ctrl;
    next_tx_hold = tx_hold;
    next_prdata = prdata;
    if (wr && paddr == serial_port_pkg::CTRL_ADDR) begin
      next_ctrl = pwdata[15:0];
    end
    if (wr && paddr == serial_port_pkg::TXDATA_ADDR) begin
      next_tx_hold = pwdata[15:0];
    end
    if (psel && !penable) begin
      unique case (paddr)
        serial_port_pkg::CTRL_ADDR: next_prdata = {16'h0000, ctrl};
        serial_port_pkg::TXDATA_ADDR: next_prdata = {16'h0000, tx_hold};
        serial_port_pkg::STATUS_ADDR: begin
          next_prdata = {24'h00_0000, bitcnt, fs, sclk,
                         state != serial_port_pkg::ST_IDLE, pending};
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // register file state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= serial_port_pkg::CTRL_RESET;
      tx_hold <= serial_port_pkg::TXDATA_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      tx_hold <= next_tx_hold;
      prdata <= next_prdata;
    end
  end

  // =========================================================
  // shift clock divider; idle counter parks so the first edge is a rise
  always_comb begin
    next_cnt = CNT_PARK;
    next_sclk = 1'b0;
    if (en) begin
      next_cnt = rise ? 8'h00 : cnt + 8'h01; // R2
      next_sclk = next_cnt < high_len; // R3 R4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= CNT_PARK;
      sclk <= 1'b0;
    end else begin
      cnt <= next_cnt;
      sclk <= next_sclk;
    end
  end

  // pins carry polarity-corrected clocks and syncs
  assign tx_shift_clock = sclk ^ ctrl[serial_port_pkg::TX_CLK_POL_BIT]; // R1
  assign rx_shift_clock = sclk ^ ctrl[serial_port_pkg::RX_CLK_POL_BIT]; // R1
  assign tx_frame_sync = fs ^ ctrl[serial_port_pkg::TX_SYNC_POL_BIT]; // R1
  assign rx_frame_sync = rx_fs ^ ctrl[serial_port_pkg::RX_SYNC_POL_BIT]; // R1
  assign tx_serial_out = tx_out;
  assign tx_serial_oe_n = oe_n;

  // =========================================================
  // receive frame sync: one bit wide, once per word of rises
  always_comb begin
    next_rx_cnt = 4'h0;
    next_rx_fs = 1'b0;
    if (en) begin
      next_rx_cnt = rx_cnt;
      next_rx_fs = rx_fs;
      if (rise) begin
        next_rx_cnt = rx_cnt + 4'h1;
        next_rx_fs = rx_cnt == 4'h0; // R6
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt <= 4'h0;
      rx_fs <= 1'b0;
    end else begin
      rx_cnt <= next_rx_cnt;
      rx_fs <= next_rx_fs;
    end
  end

  // =========================================================
  // transmit sequencer: frame sync, data delay, shift, release
  assign launch = rise && en &&
    ((state == serial_port_pkg::ST_IDLE && pending &&
      delay == serial_port_pkg::DELAY_NONE) ||
     (state == serial_port_pkg::ST_DELAY && !dly_left));

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_dly_left = dly_left;
    next_hold = hold;
    next_tx_out = tx_out;
    next_oe_n = oe_n;
    next_fs = fs;
    next_pending = pending;
    // held-back first bit comes out when the hold runs out; with divide 0 or 1 a rise lands there and the second bit wins
    if (hold != 2'h0) begin
      next_hold = hold - 2'h1;
      if (hold == 2'h1) begin
        next_oe_n = 1'b0; // R11
        next_tx_out = shreg[15];
      end
    end
    if (rise && fs) begin
      next_fs = 1'b0; // R7
    end
    unique case (state)
      serial_port_pkg::ST_IDLE: begin
        if (rise && pending) begin
          next_fs = 1'b1; // R7
          next_shreg = tx_hold;
          next_pending = 1'b0;
          next_dly_left = delay != serial_port_pkg::DELAY_ONE;
          next_state = serial_port_pkg::ST_DELAY;
        end
      end
      serial_port_pkg::ST_DELAY: begin
        if (rise) begin
          next_dly_left = 1'b0; // R9
        end
      end
      serial_port_pkg::ST_SHIFT: begin
        if (rise) begin
          if (bitcnt == LAST_BIT) begin
            next_oe_n = 1'b1; // R12
            next_hold = 2'h0;
            next_state = serial_port_pkg::ST_IDLE;
          end else begin
            next_bitcnt = bitcnt + 4'h1;
            next_shreg = {shreg[14:0], 1'b0};
            next_tx_out = shreg[14]; // R8
          end
        end
      end
    endcase
    if (launch) begin
      next_state = serial_port_pkg::ST_SHIFT;
      next_bitcnt = 4'h0;
      next_hold = extra ? HOLD_INIT : 2'h0; // R11
      next_oe_n = extra; // R9 R10
      next_tx_out = (state == serial_port_pkg::ST_IDLE) ? tx_hold[15]
                                                       : shreg[15];
    end
    // a word written while a frame starts stays pending: the set wins
    if (wr && paddr == serial_port_pkg::TXDATA_ADDR) begin
      next_pending = 1'b1;
    end
    if (!en) begin
      next_state = serial_port_pkg::ST_IDLE;
      next_oe_n = 1'b1; // R13
      next_fs = 1'b0;
      next_hold = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= serial_port_pkg::ST_IDLE;
      shreg <= 16'h0000;
      bitcnt <= 4'h0;
      dly_left <= 1'b0;
      hold <= 2'h0;
      tx_out <= 1'b0;
      oe_n <= 1'b1;
      fs <= 1'b0;
      pending <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      dly_left <= next_dly_left;
      hold <= next_hold;
      tx_out <= next_tx_out;
      oe_n <= next_oe_n;
      fs <= next_fs;
      pending <= next_pending;
    end
  end

  // =========================================================
  // checks: run length of each clock level, settled after a rise
  logic [7:0] run;
  logic settle;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 8'h00;
      settle <= 1'b0;
    end else begin
      run <= (next_sclk != sclk) ? 8'h01 : run + 8'h01;
      settle <= (wr && paddr == serial_port_pkg::CTRL_ADDR) ? 1'b0
              : (rise ? 1'b1 : settle);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_HIGH_PHASE: assert property (settle && sclk && !next_sclk |-> // R4
    run == high_len) else $error("shift clock high phase wrong");
  AST_LOW_PHASE: assert property (settle && rise && !wr |-> // R3
    run == div_eff + 8'h01 - high_len) else $error("low phase wrong");
  AST_MIN_PERIOD: assert property (rise |=> !rise) // R5
    else $error("shift clock faster than 4H");
  AST_PERIOD: assert property (settle && rise && !wr |=> // R2
    (cnt == 8'h00)) else $error("divider did not wrap on rise");
  AST_TX_FS_EDGE: assert property ($changed(fs) && en |-> // R7
    $past(rise)) else $error("tx frame sync moved off a rise");
  AST_RX_FS_EDGE: assert property ($changed(rx_fs) && en |-> // R6
    $past(rise)) else $error("rx frame sync moved off a rise");
  AST_DATA_EDGE: assert property ($changed(tx_out) |-> // R8
    $past(rise) || $past(hold) == 2'h1) else $error("data off a rise");
  AST_NO_DELAY: assert property (launch && !extra && // R10
    state == serial_port_pkg::ST_IDLE |=> !oe_n && fs)
    else $error("zero delay first bit not with sync");
  AST_DELAYED: assert property (rise && dly_left && en && // R9
    state == serial_port_pkg::ST_DELAY |=> oe_n)
    else $error("delayed first bit launched early");
  AST_EXTRA: assert property (launch && extra && rise |=> // R11
    oe_n ##1 oe_n ##1 !oe_n) else $error("extra enable hold not 4H");
  AST_RELEASE: assert property (rise && bitcnt == LAST_BIT && // R12
    state == serial_port_pkg::ST_SHIFT |=> oe_n)
    else $error("output not released after last bit");
  AST_DRIVE_ONLY_SHIFT: assert property (!oe_n |-> // R13
    state == serial_port_pkg::ST_SHIFT) else $error("driven idle");
  AST_POLARITY: assert property ($rose(sclk) && // R1
    $stable(ctrl) |-> tx_shift_clock != $past(tx_shift_clock))
    else $error("clock pin did not toggle");

  COV_NO_DELAY: cover property (launch && state == serial_port_pkg::ST_IDLE);
  COV_DELAY_TWO: cover property (rise && dly_left &&
    state == serial_port_pkg::ST_DELAY);
  COV_EXTRA: cover property (launch && extra);
  COV_FRAME_END: cover property (rise && bitcnt == LAST_BIT &&
    state == serial_port_pkg::ST_SHIFT);
endmodule

// ### tb/serial_rx_model.sv
// far-side receiver that gathers the transmitted bits of each frame
`timescale 1ns/1ps
module serial_rx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sdata_oe_n,
  output logic [15:0] word
);
  logic sclk_q;
  // =========================================================
  // shift one bit in at each falling shift clock while driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
      word <= 16'h0000;
    end else begin
      sclk_q <= sclk;
      if (sclk_q && !sclk && !sdata_oe_n) begin
        word <= {word[14:0], sdata}; // msb arrives first
      end
    end
  end
endmodule

// ### tb/buffered_serial_port_clocking_tx_tb_top.sv
// self-checking bench for the serial port transmit clocking block
`timescale 1ns/1ps
module buffered_serial_port_clocking_tx_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, tx_shift_clock, rx_shift_clock;
  logic tx_frame_sync, rx_frame_sync, tx_serial_out, tx_serial_oe_n;
  logic [15:0] rx_word;
  int err_count = 0;
  int checks_done = 0;
  // =========================================================
  // clock, design and far-side receiver
  always #2 pclk = ~pclk;
  serial_port_tx dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_shift_clock(tx_shift_clock), .rx_shift_clock(rx_shift_clock),
    .tx_frame_sync(tx_frame_sync), .rx_frame_sync(rx_frame_sync),
    .tx_serial_out(tx_serial_out), .tx_serial_oe_n(tx_serial_oe_n));
  serial_rx_model far_end (.pclk(pclk), .presetn(presetn),
    .sclk(tx_shift_clock), .sdata(tx_serial_out),
    .sdata_oe_n(tx_serial_oe_n), .word(rx_word));
  // =========================================================
  // verdict, comparison and bounded waits
  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: sig = tx_shift_clock;
      1: sig = tx_frame_sync;
      2: sig = tx_serial_oe_n;
      default: sig = rx_frame_sync;
    endcase
  endfunction
  // counts edges until the chosen pin shows the level; gives up at 1000
  task automatic wait_sig(input int k, input logic v, output int n);
    n = 0;
    while (sig(k) !== v && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 1000) begin
      chk("wait_bound", 32'h0000_0000, 32'h0000_0001);
      print_verdict();
    end
  endtask
  // =========================================================
  // apb master: setup, then access held until pready
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk("pready_bound", 32'h0000_0000, 32'h0000_0001);
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // =========================================================
  // scenarios
  task automatic regs();
    logic [31:0] r;
    logic e;
    apb(1'b0, serial_port_pkg::CTRL_ADDR, 32'h0000_0000, r, e);
    chk("ctrl_reset", 32'h0000_0000, r);
    wr(serial_port_pkg::TXDATA_ADDR, 32'hFFFF_1234);
    apb(1'b0, serial_port_pkg::TXDATA_ADDR, 32'h0000_0000, r, e);
    chk("txdata_rw", 32'h0000_1234, r);
    apb(1'b0, serial_port_pkg::STATUS_ADDR, 32'h0000_0000, r, e);
    chk("status_pending", 32'h0000_0001, r);
    apb(1'b0, 12'h00C, 32'h0000_0000, r, e);
    chk("unmapped_err", 32'h0000_0001, {31'h0000_0000, e});
    chk("unmapped_data", 32'h0000_0000, r);
    apb(1'b1, serial_port_pkg::STATUS_ADDR, 32'h0000_00FF, r, e);
    chk("status_write_err", 32'h0000_0001, {31'h0000_0000, e});
  endtask
  task automatic shape(input int dv);
    int n, hi, lo, p;
    wr(serial_port_pkg::CTRL_ADDR, {16'h0000, 8'h80, dv[7:0]});
    wait_sig(0, 1'b0, n);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, hi);
    wait_sig(0, 1'b1, lo);
    p = (dv == 0) ? 2 : dv + 1;
    chk("clk_high", (dv % 2 == 0 && dv != 0) ? dv / 2 + 1 : p / 2, hi);
    chk("clk_low", (dv % 2 == 0 && dv != 0) ? dv / 2 : p / 2, lo);
    chk("clk_period", p, hi + lo);
    wr(serial_port_pkg::CTRL_ADDR, 32'h0000_0000);
  endtask
  task automatic polarity();
    int n;
    wr(serial_port_pkg::CTRL_ADDR, 32'h0000_0F00);
    chk("syncs_inverted", 32'h0000_0003, {tx_frame_sync, rx_frame_sync});
    chk("clks_inverted", 32'h0000_0003, {tx_shift_clock, rx_shift_clock});
    wr(serial_port_pkg::CTRL_ADDR, 32'h0000_8103);
    repeat (3) begin
      @(posedge pclk);
      chk("clk_pol_split", {31'h0000_0000, ~rx_shift_clock},
          {31'h0000_0000, tx_shift_clock});
    end
    wr(serial_port_pkg::CTRL_ADDR, 32'h0000_8003);
    wait_sig(3, 1'b0, n);
    wait_sig(3, 1'b1, n);
    chk("rx_sync_on_rise", 32'h0000_0001, rx_shift_clock);
    wr(serial_port_pkg::CTRL_ADDR, 32'h0000_0000);
  endtask
  task automatic frame(input logic [1:0] dly, input logic ext, input int dv,
      input logic [15:0] w);
    int n, g;
    wr(serial_port_pkg::TXDATA_ADDR, {16'h0000, w});
    wr(serial_port_pkg::CTRL_ADDR, {16'h0000, 1'b1, ext, dly, 4'h0, dv[7:0]});
    wait_sig(1, 1'b1, n);
    chk("sync_with_clk", 32'h0000_0001, tx_shift_clock);
    wait_sig(2, 1'b0, g);
    chk("first_bit_gap", dly * (dv + 1) + (ext ? 2 : 0), g);
    wait_sig(2, 1'b1, n);
    chk("driven_len", 16 * (dv + 1) - (ext ? 2 : 0), n);
    chk("word", {16'h0000, w}, {16'h0000, rx_word});
    wr(serial_port_pkg::CTRL_ADDR, 32'h0000_0000);
    chk("idle_release", 32'h0000_0001, tx_serial_oe_n);
  endtask
  // =========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    regs();
    shape(0);
    shape(1);
    shape(2);
    shape(3);
    shape(6);
    polarity();
    frame(2'h0, 1'b0, 3, 16'hA5C3);
    frame(2'h1, 1'b0, 3, 16'h0001);
    frame(2'h2, 1'b0, 3, 16'h8000);
    frame(2'h1, 1'b1, 7, 16'h5A3C);
    frame(2'h0, 1'b1, 7, 16'hC003);
    print_verdict();
  end
endmodule
